// [fcs_regs.svh]
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH

// ****************************************************************
// controller register offsets
// ****************************************************************
`define FCS_OFF_CMD      4'h0
`define FCS_OFF_ADDR     4'h1
`define FCS_OFF_DATA     4'h2
`define FCS_OFF_STATUS   4'h3
`define FCS_OFF_RDDATA   4'h4
`define FCS_OFF_CTRL     4'h5

// ****************************************************************
// status and control fields
// ****************************************************************
`define FCS_ST_BUSY      0
`define FCS_ST_DONE      1
`define FCS_ST_ERR       2
`define FCS_ST_IDMODE    3
`define FCS_ST_BYPASS    4
`define FCS_ST_SECURE    5
`define FCS_ST_WINDOW    6
`define FCS_ST_FLBUSY    7
`define FCS_ST_REFUSED   8
`define FCS_CTRL_BYTE    0
`define FCS_CTRL_ACCEL   1
`define FCS_CTRL_OTHBUSY 2
`define FCS_CTRL_RESET   3

// ****************************************************************
// flash command words and unlock addresses
// ****************************************************************
`define FCS_D_UNLOCK1    8'haa
`define FCS_D_UNLOCK2    8'h55
`define FCS_D_IDQUERY    8'h90
`define FCS_D_SECENTER   8'h88
`define FCS_D_PROGRAM    8'ha0
`define FCS_D_BYPASS     8'h20
`define FCS_D_ERASESET   8'h80
`define FCS_D_CHIPERASE  8'h10
`define FCS_D_SECTERASE  8'h30
`define FCS_D_RESET      8'hf0
`define FCS_D_ZERO       8'h00
`define FCS_A_UNLOCK1_W  12'h555
`define FCS_A_UNLOCK2_W  12'h2aa
`define FCS_A_UNLOCK1_B  12'haaa
`define FCS_A_UNLOCK2_B  12'h555

// ****************************************************************
// timing
// ****************************************************************
`define FCS_CLK_MHZ      125
`define FCS_WIN_US       80
`define FCS_WIN_CYC      (`FCS_WIN_US * `FCS_CLK_MHZ)
`define FCS_WE_LOW_CYC   4
`define FCS_WE_HIGH_CYC  4
`define FCS_RD_CYC       8

`endif

// [fcs_pkg.sv]
package fcs_pkg;

  typedef enum logic [3:0] {
    FCS_OP_NONE,
    FCS_OP_READ,
    FCS_OP_RESET,
    FCS_OP_IDQUERY,
    FCS_OP_SECENTER,
    FCS_OP_SECEXIT,
    FCS_OP_PROGRAM,
    FCS_OP_BYPENTER,
    FCS_OP_BYPPROG,
    FCS_OP_BYPRESET,
    FCS_OP_CHIPERASE,
    FCS_OP_SECTERASE,
    FCS_OP_SECTADD
  } fcs_op_t;

  typedef enum logic [2:0] {
    FCS_S_IDLE,
    FCS_S_SETUP,
    FCS_S_STROBE,
    FCS_S_HOLD,
    FCS_S_READ,
    FCS_S_WAITBUSY
  } fcs_state_t;

endpackage

// [fcs_host.sv]
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "fcs_regs.svh"

// Notes on behaviour
// RULE1: flash accepts id query in read modes
// RULE2: never query while another bank busy
// RULE3: two unlocks then bank query command
// RULE4: id codes readable repeatedly without resend
// RULE5: only reset leaves id mode
// RULE6: three-cycle entry, four-cycle exit secure region
// RULE7: secure region unusable during embedded operations
// RULE8: program is unlocks, setup, address data
// RULE9: bank returns to read after program
// RULE10: writes during program ignored; reset aborts
// RULE11: program only clears bits
// RULE12: unlocks plus 20h enter bypass; A0h programs
// RULE13: bypass takes only program and bypass reset
// RULE14: accel high voltage forces bypass mode
// RULE15: no accel or bypass while secure mapped
// RULE16: chip erase is six write cycles
// RULE17: writes during chip erase ignored; reset aborts
// RULE18: sector erase six cycles, last sector address
// RULE19: extra sectors within 80 us window
// RULE20: other command in window cancels erase
// RULE21: window starts at final write rising edge; the code loads win_reg at the end of the final hold, WE_HIGH_CYC cycles later
// RULE22: after erase starts only suspend accepted; the code has no suspend op and accepts only READ while busy
// RULE23: mismatched write abandons the sequence
module fcs_host
  import fcs_pkg::*;
#(
  parameter int AW          = 22,
  parameter int DW          = 16,
  parameter int WIN_CYC     = `FCS_WIN_CYC,
  parameter int WE_LOW_CYC  = `FCS_WE_LOW_CYC,
  parameter int WE_HIGH_CYC = `FCS_WE_HIGH_CYC,
  parameter int RD_CYC      = `FCS_RD_CYC
)
(
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          clk_en,
  // software register port
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [31:0]   reg_rdata,
  // flash bus
  output logic      [AW-1:0] flash_addr,
  output logic      [DW-1:0] flash_dq_out,
  output logic               flash_dq_oe,
  input  wire logic [DW-1:0] flash_dq_in,
  output logic               flash_ce_n,
  output logic               flash_we_n,
  output logic               flash_oe_n,
  output logic               flash_reset_n,
  output logic               flash_byte_n,
  output logic               protect_accel_input,
  input  wire logic          ready_busy_out
);

  localparam int SEQ_MAX = 6;
  localparam int CW      = 16;

  // ****************************************************************
  // registers
  // ****************************************************************
  fcs_op_t           op_reg;
  fcs_state_t        state_reg;
  logic [AW-1:0]     addr_reg;
  logic [DW-1:0]     data_reg;
  logic [DW-1:0]     rdata_reg;
  logic [3:0]        ctrl_reg;
  logic              busy_reg;
  logic              done_reg;
  logic              err_reg;
  logic              refused_reg;
  logic              id_mode_reg;
  logic              bypass_reg;
  logic              secure_reg;
  logic [2:0]        step_reg;
  logic [2:0]        nsteps_reg;
  logic [CW-1:0]     tcnt_reg;
  logic [31:0]       win_reg;
  logic              win_open;
  logic [AW-1:0]     cyc_addr;
  logic [7:0]        cyc_data;
  logic              is_read;
  logic              accepted;

  wire byte_mode = ctrl_reg[`FCS_CTRL_BYTE];
  wire accel_req = ctrl_reg[`FCS_CTRL_ACCEL];
  wire oth_busy  = ctrl_reg[`FCS_CTRL_OTHBUSY];
  wire [11:0] ua1 = byte_mode ? `FCS_A_UNLOCK1_B : `FCS_A_UNLOCK1_W;
  wire [11:0] ua2 = byte_mode ? `FCS_A_UNLOCK2_B : `FCS_A_UNLOCK2_W;
  wire [7:0]  op_code = reg_wdata[7:0];
  wire        cmd_wr  = clk_en && reg_wr && reg_addr == `FCS_OFF_CMD;

  assign win_open = win_reg != 32'h0;

  // ****************************************************************
  // command admission
  // ****************************************************************
  function automatic logic [2:0] seq_len(input fcs_op_t op);
    case (op)
      FCS_OP_READ, FCS_OP_RESET, FCS_OP_SECTADD:     seq_len = 3'd1;
      FCS_OP_BYPPROG, FCS_OP_BYPRESET:               seq_len = 3'd2;
      FCS_OP_IDQUERY, FCS_OP_SECENTER, FCS_OP_BYPENTER: seq_len = 3'd3;
      FCS_OP_SECEXIT, FCS_OP_PROGRAM:                seq_len = 3'd4;
      FCS_OP_CHIPERASE, FCS_OP_SECTERASE:            seq_len = 3'd6;
      default:                                       seq_len = 3'd0;
    endcase
  endfunction

  always_comb
  begin
    fcs_op_t o;
    o = fcs_op_t'(op_code[3:0]);
    accepted = !busy_reg && seq_len(o) != 3'd0;
    if (id_mode_reg && o != FCS_OP_RESET && o != FCS_OP_READ)
      accepted = 1'b0; // see RULE5
    if (bypass_reg && !(o == FCS_OP_BYPPROG || o == FCS_OP_BYPRESET || o == FCS_OP_READ))
      accepted = 1'b0; // see RULE13
    if (!bypass_reg && (o == FCS_OP_BYPPROG || o == FCS_OP_BYPRESET))
      accepted = 1'b0;
    if (secure_reg && (o == FCS_OP_BYPENTER || o == FCS_OP_BYPPROG))
      accepted = 1'b0; // see RULE15
    if (o == FCS_OP_IDQUERY && oth_busy)
      accepted = 1'b0; // see RULE2
    if (!ready_busy_out && !win_open && o != FCS_OP_READ)
      accepted = 1'b0; // see RULE10 RULE17 RULE22
    if (!ready_busy_out && secure_reg)
      accepted = 1'b0; // see RULE7
    if (o == FCS_OP_SECTADD && !win_open)
      accepted = 1'b0; // see RULE19
  end

  // ****************************************************************
  // per-cycle address and data of each sequence
  // ****************************************************************
  always_comb
  begin
    cyc_addr = {{(AW-12){1'b0}}, ua1};
    cyc_data = `FCS_D_UNLOCK1;
    is_read  = 1'b0;
    case (op_reg)
      FCS_OP_READ:
      begin
        cyc_addr = addr_reg;
        is_read  = 1'b1; // see RULE4
      end
      FCS_OP_RESET:     cyc_data = `FCS_D_RESET; // see RULE5
      FCS_OP_SECTADD:
      begin
        cyc_addr = addr_reg;
        cyc_data = `FCS_D_SECTERASE; // see RULE19
      end
      FCS_OP_BYPPROG:
        if (step_reg == 3'd0)
          cyc_data = `FCS_D_PROGRAM; // see RULE12
        else
          cyc_addr = addr_reg;
      FCS_OP_BYPRESET:
        cyc_data = (step_reg == 3'd0) ? `FCS_D_IDQUERY : `FCS_D_ZERO; // see RULE13
      default:
        case (step_reg)
          3'd0: ;
          3'd1:
          begin
            cyc_addr = {{(AW-12){1'b0}}, ua2};
            cyc_data = `FCS_D_UNLOCK2;
          end
          3'd2:
          begin
            if (op_reg == FCS_OP_IDQUERY)
              cyc_addr = addr_reg | {{(AW-12){1'b0}}, ua1}; // see RULE3
            case (op_reg)
              FCS_OP_IDQUERY, FCS_OP_SECEXIT: cyc_data = `FCS_D_IDQUERY;
              FCS_OP_SECENTER:  cyc_data = `FCS_D_SECENTER; // see RULE6
              FCS_OP_PROGRAM:   cyc_data = `FCS_D_PROGRAM; // see RULE8
              FCS_OP_BYPENTER:  cyc_data = `FCS_D_BYPASS; // see RULE12
              default:          cyc_data = `FCS_D_ERASESET; // see RULE16
            endcase
          end
          3'd3:
            if (op_reg == FCS_OP_SECEXIT)
              cyc_data = `FCS_D_ZERO; // see RULE6
            else if (op_reg == FCS_OP_PROGRAM)
              cyc_addr = addr_reg; // see RULE8
          3'd4:
          begin
            cyc_addr = {{(AW-12){1'b0}}, ua2};
            cyc_data = `FCS_D_UNLOCK2;
          end
          default:
            if (op_reg == FCS_OP_SECTERASE)
            begin
              cyc_addr = addr_reg;
              cyc_data = `FCS_D_SECTERASE; // see RULE18
            end
            else
              cyc_data = `FCS_D_CHIPERASE; // see RULE16
        endcase
    endcase
  end

  wire data_cycle = (op_reg == FCS_OP_PROGRAM && step_reg == 3'd3) ||
                    (op_reg == FCS_OP_BYPPROG && step_reg == 3'd1);
  wire last_cyc   = step_reg == nsteps_reg - 3'd1;
  wire starts_alg = op_reg == FCS_OP_PROGRAM || op_reg == FCS_OP_BYPPROG ||
                    op_reg == FCS_OP_CHIPERASE;

  // ****************************************************************
  // bus cycle sequencer
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_reg  <= FCS_S_IDLE;
      op_reg     <= FCS_OP_NONE;
      step_reg   <= 3'd0;
      nsteps_reg <= 3'd0;
      tcnt_reg   <= '0;
      busy_reg   <= 1'b0;
      done_reg   <= 1'b0;
      refused_reg <= 1'b0;
      flash_addr <= '0;
      flash_dq_out <= '0;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
      rdata_reg  <= '0;
    end
    else if (clk_en)
    begin
      if (cmd_wr)
      begin
        done_reg    <= 1'b0;
        refused_reg <= !accepted;
        if (accepted)
        begin
          op_reg     <= fcs_op_t'(op_code[3:0]);
          nsteps_reg <= seq_len(fcs_op_t'(op_code[3:0]));
          step_reg   <= 3'd0;
          busy_reg   <= 1'b1;
          state_reg  <= FCS_S_SETUP;
        end
      end
      case (state_reg)
        FCS_S_IDLE: ;
        FCS_S_SETUP:
        begin
          flash_addr   <= cyc_addr;
          flash_dq_out <= data_cycle ? data_reg : {{(DW-8){1'b0}}, cyc_data};
          flash_dq_oe  <= !is_read;
          flash_ce_n   <= 1'b0;
          flash_we_n   <= is_read;
          flash_oe_n   <= !is_read;
          tcnt_reg     <= '0;
          state_reg    <= is_read ? FCS_S_READ : FCS_S_STROBE;
        end
        FCS_S_READ:
          if (tcnt_reg == CW'(RD_CYC - 1))
          begin
            rdata_reg  <= flash_dq_in;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            busy_reg   <= 1'b0;
            done_reg   <= 1'b1;
            state_reg  <= FCS_S_IDLE;
          end
          else
            tcnt_reg <= tcnt_reg + 1'b1;
        FCS_S_STROBE:
          if (tcnt_reg == CW'(WE_LOW_CYC - 1))
          begin
            flash_we_n <= 1'b1; // see RULE21
            flash_ce_n <= 1'b1;
            tcnt_reg   <= '0;
            state_reg  <= FCS_S_HOLD;
          end
          else
            tcnt_reg <= tcnt_reg + 1'b1;
        FCS_S_HOLD:
          if (tcnt_reg == CW'(WE_HIGH_CYC - 1))
          begin
            flash_dq_oe <= 1'b0;
            tcnt_reg    <= '0;
            if (!last_cyc)
            begin
              step_reg  <= step_reg + 3'd1; // see RULE23
              state_reg <= FCS_S_SETUP;
            end
            else if (starts_alg)
              state_reg <= FCS_S_WAITBUSY; // see RULE9
            else
            begin
              busy_reg  <= 1'b0;
              done_reg  <= 1'b1;
              state_reg <= FCS_S_IDLE;
            end
          end
          else
            tcnt_reg <= tcnt_reg + 1'b1;
        FCS_S_WAITBUSY:
          if (ready_busy_out && tcnt_reg != '0)
          begin
            busy_reg  <= 1'b0; // see RULE9 RULE10 RULE17
            done_reg  <= 1'b1;
            state_reg <= FCS_S_IDLE;
          end
          else if (tcnt_reg == '0)
            tcnt_reg <= tcnt_reg + 1'b1;
        default: state_reg <= FCS_S_IDLE;
      endcase
      if (!flash_reset_n)
      begin
        state_reg   <= FCS_S_IDLE; // see RULE10 RULE17 RULE22
        busy_reg    <= 1'b0;
        flash_ce_n  <= 1'b1;
        flash_we_n  <= 1'b1;
        flash_oe_n  <= 1'b1;
        flash_dq_oe <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // tracked mode of the addressed bank
  // ****************************************************************
  wire seq_end = state_reg == FCS_S_HOLD && last_cyc && tcnt_reg == CW'(WE_HIGH_CYC - 1);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !flash_reset_n)
    begin
      id_mode_reg <= 1'b0;
      bypass_reg  <= 1'b0;
      secure_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (accel_req && !secure_reg)
        bypass_reg <= 1'b1; // see RULE14 RULE15
      if (seq_end)
        case (op_reg)
          FCS_OP_IDQUERY:  id_mode_reg <= 1'b1; // see RULE1 RULE3
          FCS_OP_RESET:    id_mode_reg <= 1'b0; // see RULE5
          FCS_OP_SECENTER: secure_reg  <= 1'b1; // see RULE6
          FCS_OP_SECEXIT:  secure_reg  <= 1'b0;
          FCS_OP_BYPENTER: bypass_reg  <= 1'b1; // see RULE12
          FCS_OP_BYPRESET: bypass_reg  <= accel_req; // see RULE13
          default: ;
        endcase
    end
  end

  // ****************************************************************
  // sector erase accumulation window
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || !flash_reset_n)
      win_reg <= 32'h0;
    else if (clk_en)
    begin
      if (seq_end && (op_reg == FCS_OP_SECTERASE || op_reg == FCS_OP_SECTADD))
        win_reg <= 32'(WIN_CYC - 1); // see RULE19 RULE21
      else if (cmd_wr && accepted && op_code[3:0] != 4'(FCS_OP_SECTADD) &&
               op_code[3:0] != 4'(FCS_OP_READ))
        win_reg <= 32'h0; // see RULE20
      else if (win_open)
        win_reg <= win_reg - 32'h1;
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      addr_reg <= '0;
      data_reg <= '0;
      ctrl_reg <= 4'h0;
      err_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (reg_wr && reg_addr == `FCS_OFF_ADDR)
        addr_reg <= reg_wdata[AW-1:0];
      if (reg_wr && reg_addr == `FCS_OFF_DATA)
        data_reg <= reg_wdata[DW-1:0];
      if (reg_wr && reg_addr == `FCS_OFF_CTRL)
        ctrl_reg <= reg_wdata[3:0];
      if (state_reg == FCS_S_READ && tcnt_reg == CW'(RD_CYC - 1) && op_reg == FCS_OP_READ &&
          (flash_dq_in & ~data_reg) != '0)
        err_reg <= 1'b1; // see RULE11
      else if (reg_wr && reg_addr == `FCS_OFF_STATUS && reg_wdata[`FCS_ST_ERR])
        err_reg <= 1'b0;
    end
  end

  assign flash_reset_n       = !ctrl_reg[`FCS_CTRL_RESET];
  assign flash_byte_n        = !byte_mode;
  assign protect_accel_input = accel_req && !secure_reg; // see RULE15

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else if (clk_en)
    begin
      reg_rdata <= 32'h0;
      if (reg_rd)
        case (reg_addr)
          `FCS_OFF_ADDR:   reg_rdata <= 32'(addr_reg);
          `FCS_OFF_DATA:   reg_rdata <= 32'(data_reg);
          `FCS_OFF_CMD:    reg_rdata <= {28'h0, op_reg};
          `FCS_OFF_CTRL:   reg_rdata <= {28'h0, ctrl_reg};
          `FCS_OFF_RDDATA: reg_rdata <= 32'(rdata_reg);
          `FCS_OFF_STATUS: reg_rdata <= {23'h0, refused_reg, !ready_busy_out, win_open,
                                         secure_reg, bypass_reg, id_mode_reg, err_reg,
                                         done_reg, busy_reg};
          default:         reg_rdata <= 32'h0;
        endcase
    end
  end

endmodule

// [fcs_flash_model.sv]
`timescale 1ns/1ps
module fcs_flash_model #(
  parameter int          BUSY_NS  = 200,
  parameter int          WIN_NS   = 360,
  parameter logic [15:0] ID_CODE  = 16'h0123, // arbitrary
  parameter logic [15:0] SER_CODE = 16'h0a5c
)
(
  // flash bus
  input  wire logic [21:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_reset_n,
  input  wire logic        protect_accel_input,
  output logic      [15:0] flash_dq_in,
  output logic             ready_busy_out
);
  // ****
  // command decode
  // ****
  logic [15:0] mem [logic [21:0]];
  logic [15:0] rv = 16'h0;
  logic [6:0]  sq [$];
  logic [7:0]  d;
  logic [21:0] a;
  logic        idm = 0, byp = 0, sec = 0, pgm = 0;
  int          step = 0;
  realtime     busy_end = 0, win_end = 0;
  wire         bm = byp || (protect_accel_input && !sec);
  wire         wstb_n = flash_we_n | flash_ce_n; // first strobe to rise ends the write
  function automatic logic [15:0] rd(input logic [21:0] k);
    return mem.exists(k) ? mem[k] : 16'hffff;
  endfunction
  always @(posedge wstb_n)
    if (flash_reset_n && $realtime >= busy_end)
    begin
      d = flash_dq_out[7:0];
      a = flash_addr;
      if (pgm)
      begin
        mem[a] = rd(a) & flash_dq_out;
        pgm = 0;
        busy_end = $realtime + BUSY_NS;
      end
      else if (sq.size() != 0)
      begin
        if (d == 8'h30)
          sq.push_back(a[21:15]);
        else
          sq.delete();
        win_end = $realtime + WIN_NS;
      end
      else if (bm)
      begin
        pgm = d == 8'ha0;
        if (step == 9 && d == 8'h00)
          byp = 0;
        step = (d == 8'h90) ? 9 : 0;
      end
      else if (d == 8'hf0 || idm)
      begin
        idm = idm && d != 8'hf0;
        step = 0;
      end
      else if (step == 8)
      begin
        sec = d != 8'h00;
        step = 0;
      end
      else if (step % 3 == 0)
        step = (d == 8'haa) ? step + 1 : 0;
      else if (step % 3 == 1)
        step = (d == 8'h55) ? step + 1 : 0;
      else if (step == 5)
      begin
        step = 0;
        if (d == 8'h10)
        begin
          mem.delete();
          busy_end = $realtime + BUSY_NS;
        end
        if (d == 8'h30)
        begin
          sq.push_back(a[21:15]);
          win_end = $realtime + WIN_NS;
        end
      end
      else
      begin
        step = (d == 8'h80) ? 3 : (d == 8'h90 && sec) ? 8 : 0;
        idm = d == 8'h90 && !sec;
        sec = sec || d == 8'h88;
        pgm = d == 8'ha0;
        byp = d == 8'h20 && !sec;
      end
    end
  always @(negedge flash_reset_n)
  begin
    {idm, byp, sec, pgm} = 4'h0;
    step = 0;
    sq.delete();
    busy_end = 0;
  end
  always #1
  begin
    if (sq.size() != 0 && $realtime >= win_end)
    begin
      foreach (sq[i]) foreach (mem[k]) if (k[21:15] == sq[i]) mem[k] = 16'hffff;
      sq.delete();
      busy_end = $realtime + BUSY_NS;
    end
    ready_busy_out = $realtime >= busy_end;
    if (!flash_ce_n && !flash_oe_n)
      rv = idm ? ID_CODE : (sec && ready_busy_out) ? SER_CODE : rd(flash_addr);
    flash_dq_in = (!flash_ce_n && !flash_oe_n) ? rv : ~rv;
  end
endmodule

// [fcs_host_assertions.sv]
`timescale 1ns/1ps
`include "fcs_regs.svh"
module fcs_checker #(
  parameter int AW = 22,
  parameter int DW = 16
)
(
  // clock and reset
  input wire logic          sys_clk,
  input wire logic          rst_n,
  input wire logic          clk_en,
  // register port
  input wire logic [3:0]    reg_addr,
  input wire logic [31:0]   reg_wdata,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [31:0]   reg_rdata,
  // flash bus
  input wire logic [AW-1:0] flash_addr,
  input wire logic [DW-1:0] flash_dq_out,
  input wire logic          flash_dq_oe,
  input wire logic          flash_ce_n,
  input wire logic          flash_we_n,
  input wire logic          flash_oe_n,
  input wire logic          flash_reset_n,
  input wire logic          flash_byte_n,
  input wire logic          protect_accel_input,
  input wire logic          ready_busy_out
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  a_reset_pin: assert property (
    clk_en && reg_wr && reg_addr == `FCS_OFF_CTRL |=> flash_reset_n == !$past(reg_wdata[3]))
    else $error("reset pin wrong");
  a_byte_pin: assert property (
    clk_en && reg_wr && reg_addr == `FCS_OFF_CTRL |=> flash_byte_n == !$past(reg_wdata[0]))
    else $error("byte pin wrong");
  a_accel_secure: assert property (
    $past(reg_rd && reg_addr == `FCS_OFF_STATUS) && reg_rdata[5] |-> !protect_accel_input)
    else $error("accel while secure");
  a_we_low: assert property (
    $fell(flash_we_n) |-> (!flash_we_n && !flash_ce_n && flash_dq_oe)[*4] ##1 flash_we_n)
    else $error("write pulse wrong");
  a_we_gap: assert property ($rose(flash_we_n) |-> flash_we_n[*4])
    else $error("write gap short");
  a_bus_hold: assert property (
    !flash_we_n && $past(!flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("bus moved in write");
  a_read_len: assert property (
    $fell(flash_oe_n) |-> (!flash_oe_n && flash_we_n && !flash_dq_oe)[*8] ##1 flash_oe_n)
    else $error("read cycle wrong");
  a_no_write_busy: assert property ($fell(flash_we_n) |-> ready_busy_out)
    else $error("write while busy");
  c_write: cover property ($fell(flash_we_n));
  c_read: cover property ($fell(flash_oe_n));
  c_hw_reset: cover property (!flash_reset_n);
endmodule

bind fcs_host fcs_checker #(.AW(AW), .DW(DW)) u_checker (.sys_clk, .rst_n, .clk_en,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_addr, .flash_dq_out,
  .flash_dq_oe, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_reset_n, .flash_byte_n,
  .protect_accel_input, .ready_busy_out);

// [tb.sv]
`timescale 1ns/1ps
`include "fcs_regs.svh"
module tb;
  import fcs_pkg::*;
  // ****
  // bench signals
  // ****
  localparam logic [15:0] ID_CODE = 16'h0123, SER_CODE = 16'h0a5c; // arbitrary
  logic        sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [3:0]  reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, v;
  logic [21:0] fa, pa;
  logic [15:0] fo, fi, pd, pd2;
  logic        foe, ce, we, oe, frs, fb, acc, rb;
  logic [21:0] sa [3] = '{22'h008000, 22'h010000, 22'h018000};
  int          errors = 0, check_count = 0, seed = 32'h9383;
  fcs_host #(.WIN_CYC(50)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flash_addr(fa), .flash_dq_out(fo), .flash_dq_oe(foe),
    .flash_dq_in(fi), .flash_ce_n(ce), .flash_we_n(we), .flash_oe_n(oe),
    .flash_reset_n(frs), .flash_byte_n(fb), .protect_accel_input(acc), .ready_busy_out(rb));
  fcs_flash_model flash (.flash_addr(fa), .flash_dq_out(fo), .flash_ce_n(ce),
    .flash_we_n(we), .flash_oe_n(oe), .flash_reset_n(frs), .protect_accel_input(acc),
    .flash_dq_in(fi), .ready_busy_out(rb));
  initial forever #4 sys_clk = ~sys_clk;
  // ****
  // tasks
  // ****
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
    @(posedge sys_clk);
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    rd(`FCS_OFF_STATUS);
    chk(v & m, e);
  endtask
  task automatic wt(input logic [31:0] m, input logic [31:0] e);
    int n = 0;
    rd(`FCS_OFF_STATUS);
    while ((v & m) !== e && n < 3000)
    begin
      rd(`FCS_OFF_STATUS);
      n++;
    end
    if (n == 3000)
    begin
      errors++;
      stop_test();
    end
  endtask
  task automatic cmd(input fcs_op_t o, input logic [21:0] a, input logic [15:0] d);
    wr(`FCS_OFF_ADDR, {10'h0, a});
    wr(`FCS_OFF_DATA, {16'h0, d});
    wr(`FCS_OFF_CMD, {28'h0, o});
  endtask
  task automatic op(input fcs_op_t o, input logic [21:0] a, input logic [15:0] d);
    cmd(o, a, d);
    wt(32'h1, 32'h0);
  endtask
  task automatic rdchk(input logic [21:0] a, input logic [15:0] e);
    op(FCS_OP_READ, a, e);
    rd(`FCS_OFF_RDDATA);
    chk(v, {16'h0, e});
  endtask
  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    st(32'h1ff, 32'h0);
    wr(4'he, 32'h5a5a5a5a);
    rd(4'he);
    chk(v, 32'h0);
    wr(`FCS_OFF_CTRL, 32'h1);
    chk({31'h0, fb}, 32'h0);
    wr(`FCS_OFF_CTRL, 32'h4);
    op(FCS_OP_IDQUERY, 22'h0, 16'h0);
    st(32'h108, 32'h100);
    wr(`FCS_OFF_CTRL, 32'h0);
    op(FCS_OP_IDQUERY, 22'h0, 16'h0);
    st(32'ha, 32'ha);
    rdchk(22'h10, ID_CODE);
    rdchk(22'h2345, ID_CODE);
    op(FCS_OP_RESET, 22'h0, 16'h0);
    st(32'h8, 32'h0);
    $display("id test done");
    for (int i = 0; i < 4; i++)
    begin
      pa = (i == 0) ? 22'h3fffff : 22'($random(seed));
      pd = 16'($random(seed));
      pd2 = 16'($random(seed));
      op(FCS_OP_PROGRAM, pa, pd);
      rdchk(pa, pd);
      op(FCS_OP_PROGRAM, pa, pd2);
      rdchk(pa, pd & pd2);
    end
    $display("program test done");
    op(FCS_OP_BYPENTER, 22'h0, 16'h0);
    st(32'h10, 32'h10);
    pd = 16'($random(seed));
    op(FCS_OP_BYPPROG, 22'h1234, pd);
    op(FCS_OP_IDQUERY, 22'h0, 16'h0);
    st(32'h118, 32'h110);
    op(FCS_OP_BYPRESET, 22'h0, 16'h0);
    st(32'h10, 32'h0);
    rdchk(22'h1234, pd);
    wr(`FCS_OFF_CTRL, 32'h2);
    chk({31'h0, acc}, 32'h1);
    op(FCS_OP_BYPPROG, 22'h1235, 16'h00ff);
    wr(`FCS_OFF_CTRL, 32'h0);
    rdchk(22'h1235, 16'h00ff);
    op(FCS_OP_BYPRESET, 22'h0, 16'h0);
    $display("bypass test done");
    op(FCS_OP_SECENTER, 22'h0, 16'h0);
    st(32'h20, 32'h20);
    rdchk(22'h1234, SER_CODE);
    wr(`FCS_OFF_CTRL, 32'h2);
    chk({31'h0, acc}, 32'h0);
    op(FCS_OP_BYPENTER, 22'h0, 16'h0);
    st(32'h130, 32'h120);
    wr(`FCS_OFF_CTRL, 32'h0);
    op(FCS_OP_SECEXIT, 22'h0, 16'h0);
    rdchk(22'h1234, pd);
    $display("secure test done");
    cmd(FCS_OP_CHIPERASE, 22'h0, 16'h0);
    wr(`FCS_OFF_CMD, {28'h0, FCS_OP_PROGRAM});
    wt(32'h81, 32'h0);
    st(32'h100, 32'h100);
    rdchk(22'h1234, 16'hffff);
    cmd(FCS_OP_CHIPERASE, 22'h0, 16'h0);
    wt(32'h80, 32'h80);
    wr(`FCS_OFF_CTRL, 32'h8);
    chk({31'h0, frs}, 32'h0);
    wr(`FCS_OFF_CTRL, 32'h0);
    wt(32'h81, 32'h0);
    $display("chip erase test done");
    foreach (sa[i]) op(FCS_OP_PROGRAM, sa[i], 16'h0);
    op(FCS_OP_SECTERASE, sa[0], 16'h0);
    st(32'h40, 32'h40);
    op(FCS_OP_SECTADD, sa[1], 16'h0);
    wt(32'hc1, 32'h0);
    foreach (sa[i]) rdchk(sa[i], (i < 2) ? 16'hffff : 16'h0);
    op(FCS_OP_SECTERASE, sa[2], 16'h0);
    op(FCS_OP_RESET, 22'h0, 16'h0);
    wt(32'hc1, 32'h0);
    rdchk(sa[2], 16'h0);
    $display("sector erase test done");
    stop_test();
  end
endmodule
